// [bench/ftr_jtag_ctrl.sv]
`timescale 1ns/1ns
module ftr_jtag_ctrl (
  input  wire  sys_clk_i,
  input  wire  tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  logic dummy;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b1;
  end
  // Returns the serial output seen just before this period's rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge sys_clk_i);
    tms_o = tms;
    tdi_o = tdi;
    repeat (4) @(negedge sys_clk_i);
    tdo = tdo_i;
    tck_o = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    tck_o = 1'b0;
  endtask
  task automatic tms_reset;
    repeat (5) step(1'b1, 1'b1, dummy);
  endtask
  task automatic set_trst(input logic v);
    @(negedge sys_clk_i);
    trst_n_o = v;
  endtask
endmodule

// [bench/ftr_tap_properties.sv]
`timescale 1ns/1ns
`include "ftr_defines.vh"
module ftr_tap_properties (
  input wire       sys_clk_i,
  input wire       rstn_i,
  input wire       tck_i,
  input wire       tms_i,
  input wire       trst_n_i,
  input wire       fifo_q_oe_n_o,
  input wire       tdo_o,
  input wire       tdo_oe_n_o,
  input wire [3:0] tap_state_o,
  input wire       tap_reset_done_o
);
  logic       tck_q;
  logic [2:0] hi_cnt;
  // Raw pin rises with mode select high, saturating at five
  always_ff @(posedge sys_clk_i) begin
    tck_q <= tck_i;
    if (!rstn_i) hi_cnt <= 3'h0;
    else if (tck_i && !tck_q) hi_cnt <= !tms_i ? 3'h0 : hi_cnt + {2'h0, hi_cnt != 3'h5};
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_tlr_done;
    ##[1:6] (tap_state_o == `FTR_ST_TLR && tap_reset_done_o);
  endsequence
  sequence s_trst_held;
    !trst_n_i [*5];
  endsequence
  a_tdo_on_fall: assert property ($changed({tdo_o, tdo_oe_n_o}) |-> !tck_i && !$past(tck_i, 2))
    else $error("tdo moved off a fall");
  a_oe_in_shift: assert property ($fell(tdo_oe_n_o) |->
    tap_state_o inside {`FTR_ST_SH_DR, `FTR_ST_SH_IR}) else $error("tdo driven outside shift");
  a_tlr_floats: assert property (tap_state_o == `FTR_ST_TLR |-> tdo_oe_n_o)
    else $error("tdo driven in reset state");
  a_state_on_rise: assert property ($changed(tap_state_o) |->
    $past(tck_i, 2) || !$past(trst_n_i, 2) || !$past(trst_n_i, 3)) else $error("state moved alone");
  a_trst_async: assert property (s_trst_held |->
    tap_state_o == `FTR_ST_TLR && tap_reset_done_o && tdo_oe_n_o) else $error("test reset ignored");
  a_tms_five: assert property ($rose(hi_cnt == 3'h5) |-> s_tlr_done)
    else $error("five highs did not reset");
  a_fifo_float: assert property (!tap_reset_done_o |-> fifo_q_oe_n_o)
    else $error("fifo driven before reset");
  a_fifo_enable: assert property ($rose(tap_reset_done_o) |=> !fifo_q_oe_n_o)
    else $error("fifo not driven after reset");
endmodule
bind ftr_tap ftr_tap_properties ftr_tap_properties_inst (.*);

// [bench/test_ftr_tap.sv]
`timescale 1ns/1ns
`include "ftr_defines.vh"
module test_ftr_tap;
  localparam logic [31:0] ID = 32'h5a3c_0f01; // Arbitrary value
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [35:0] fifo_q = 36'h0;
  wire  [35:0] fifo_q_o;
  wire  [3:0]  state;
  wire         tck, tms, tdi, trst_n, tdo, tdo_oe_n, q_oe_n, done, tdo_pin;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic        d;
  always #4 sys_clk = ~sys_clk;
  assign tdo_pin = tdo_oe_n ? 1'bz : tdo;
  ftr_tap #(.ID_CODE(ID)) ftr_tap_inst (.sys_clk_i(sys_clk), .rstn_i(rstn), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .fifo_q_i(fifo_q), .fifo_q_o(fifo_q_o),
    .fifo_q_oe_n_o(q_oe_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .tap_state_o(state),
    .tap_reset_done_o(done));
  ftr_jtag_ctrl ftr_jtag_ctrl_inst (.sys_clk_i(sys_clk), .tdo_i(tdo_pin), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
  task automatic summarize;
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Mode-select bits LSB first, test data held low
  task automatic walk(input logic [7:0] tms_bits, input int n);
    for (int i = 0; i < n; i++) ftr_jtag_ctrl_inst.step(tms_bits[i], 1'b0, d);
  endtask
  task automatic t_power_up;
    walk(8'h0f, 5); // Four highs fall one short of a reset
    chk(q_oe_n, 1'b1);
    chk(done, 1'b0);
    chk(state, `FTR_ST_RTI);
    chk(d, 1'bz);
  endtask
  task automatic t_tms_reset;
    ftr_jtag_ctrl_inst.tms_reset();
    repeat (3) @(negedge sys_clk);
    chk(state, `FTR_ST_TLR);
    chk(done, 1'b1);
    fifo_q = 36'h9_a5c3_1e7b;
    repeat (2) @(negedge sys_clk);
    chk(q_oe_n, 1'b0);
    chk(fifo_q_o, 36'h9_a5c3_1e7b);
  endtask
  task automatic t_idcode;
    walk(8'h02, 4);
    for (int i = 0; i < 32; i++) begin
      ftr_jtag_ctrl_inst.step(i == 31, 1'b0, d);
      chk(d, ID[i]);
    end
    ftr_jtag_ctrl_inst.step(1'b0, 1'b0, d);
    chk(d, 1'bz);
    walk(8'h03, 3);
  endtask
  task automatic t_ir_bypass;
    logic [8:0] pat = 9'h0b2;
    walk(8'h03, 4);
    for (int i = 0; i < 4; i++) begin
      ftr_jtag_ctrl_inst.step(i == 3, 1'b1, d);
      chk(d, i == 0);
    end
    walk(8'h05, 5);
    for (int i = 0; i < 9; i++) begin
      ftr_jtag_ctrl_inst.step(i == 8, pat[i], d);
      chk(d, i == 0 ? 1'b0 : pat[i-1]);
    end
    walk(8'h01, 2);
    chk(d, 1'bz);
  endtask
  task automatic t_trst;
    rstn = 1'b0;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(done, 1'b0);
    walk(8'h02, 5);
    chk(d === 1'bz, 1'b0);
    // Pulsed the way a tied FIFO master reset would pulse it
    ftr_jtag_ctrl_inst.set_trst(1'b0);
    repeat (6) @(negedge sys_clk);
    chk(state, `FTR_ST_TLR);
    chk(done, 1'b1);
    chk(tdo_pin, 1'bz);
    walk(8'h02, 4);
    chk(state, `FTR_ST_TLR);
    chk(q_oe_n, 1'b0);
    ftr_jtag_ctrl_inst.set_trst(1'b1);
    repeat (2) @(negedge sys_clk);
    chk(q_oe_n, 1'b0);
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_power_up();
    t_tms_reset();
    t_idcode();
    t_ir_bypass();
    t_trst();
    summarize();
  end
  // The run needs about 880 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
endmodule

// [common/ftr_defines.vh]
`ifndef FTR_DEFINES_VH
`define FTR_DEFINES_VH

// TAP controller state codes
`define FTR_ST_TLR      4'h0
`define FTR_ST_RTI      4'h1
`define FTR_ST_SEL_DR   4'h2
`define FTR_ST_CAP_DR   4'h3
`define FTR_ST_SH_DR    4'h4
`define FTR_ST_EX1_DR   4'h5
`define FTR_ST_PAU_DR   4'h6
`define FTR_ST_EX2_DR   4'h7
`define FTR_ST_UPD_DR   4'h8
`define FTR_ST_SEL_IR   4'h9
`define FTR_ST_CAP_IR   4'ha
`define FTR_ST_SH_IR    4'hb
`define FTR_ST_EX1_IR   4'hc
`define FTR_ST_PAU_IR   4'hd
`define FTR_ST_EX2_IR   4'he
`define FTR_ST_UPD_IR   4'hf

// Instruction register layout and codes
`define FTR_IR_WIDTH    4
`define FTR_IR_CAPTURE  4'h1
`define FTR_IR_IDCODE   4'h2
`define FTR_IR_BYPASS   4'hf

// Identification register
`define FTR_ID_WIDTH    32
`define FTR_ID_RESET    32'h0000_0001

// Consecutive mode-select highs that force the TAP into reset
`define FTR_TMS_RESET_COUNT 3'h5

`endif

// [hw/ftr_sync.v]
`timescale 1ns/1ns
module ftr_sync #(
  parameter WIDTH = 4
) (
  input  wire             sys_clk_i,
  input  wire             rstn_i,
  input  wire [WIDTH-1:0] async_i,
  input  wire [WIDTH-1:0] reset_val_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      // Reset value is a tie-off, taken synchronously so no port feeds an async reset
      always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
          stage1[g] <= reset_val_i[g];
          stage2[g] <= reset_val_i[g];
        end else begin
          stage1[g] <= async_i[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  assign sync_o = stage2;

endmodule

// [hw/ftr_tap.v]
`timescale 1ns/1ns
`include "ftr_defines.vh"
// Function
// - Serial test data output changes only on a falling test clock edge or an asserted test or system reset.
// - Test data output floats except in the two shifting states.
// - Test data output comes from instruction, identification or bypass register.
// - Mode select steers every TAP state transition except a test or system reset.
// - Asserted test reset forces the TAP to reset without a test clock edge.
// - Five consecutive mode-select highs on test clock reset the TAP.
// - FIFO data outputs float until the TAP has been properly reset.
// - Mode select and test data in are sampled on rising test clock.
module ftr_tap #(
  parameter DATA_WIDTH = 36,
  parameter [`FTR_ID_WIDTH-1:0] ID_CODE = `FTR_ID_RESET // Arbitrary neutral value
) (
  input  wire                     sys_clk_i,
  input  wire                     rstn_i,
  input  wire                     tck_i,
  input  wire                     tms_i,
  input  wire                     tdi_i,
  input  wire                     trst_n_i,
  input  wire [DATA_WIDTH-1:0]    fifo_q_i,
  output reg  [DATA_WIDTH-1:0]    fifo_q_o,
  output reg                      fifo_q_oe_n_o,
  output reg                      tdo_o,
  output reg                      tdo_oe_n_o,
  output wire [3:0]               tap_state_o,
  output reg                      tap_reset_done_o
);

  localparam IRW = `FTR_IR_WIDTH;
  localparam IDW = `FTR_ID_WIDTH;

  wire [3:0] pins_s;
  wire       tck_s;
  wire       tms_s;
  wire       tdi_s;
  wire       trst_n_s;

  reg        tck_d;
  reg  [3:0] state;
  reg  [3:0] next_state;
  reg  [2:0] tms_cnt;
  reg  [IRW-1:0] ir;
  reg  [IRW-1:0] ir_sh;
  reg  [IDW-1:0] id_sh;
  reg        bypass_bit;

  wire       tck_rise;
  wire       tck_fall;
  wire       sel_id;
  wire       shifting;
  wire       tms_reset_hit;

  // All four pins cross together so their relative timing is kept
  // Reset values are the idle pin levels: an asserted test reset here would
  // otherwise fake a proper TAP reset right after system reset
  ftr_sync #(
    .WIDTH (4)
  ) u_sync (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .async_i     ({trst_n_i, tdi_i, tms_i, tck_i}),
    .reset_val_i (4'he),
    .sync_o      (pins_s)
  );

  assign tck_s    = pins_s[0];
  assign tms_s    = pins_s[1];
  assign tdi_s    = pins_s[2];
  assign trst_n_s = pins_s[3];

  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  assign shifting = (state == `FTR_ST_SH_DR) || (state == `FTR_ST_SH_IR);
  assign sel_id   = (ir == `FTR_IR_IDCODE);
  assign tap_state_o = state;

  // Fourth consecutive high already counted plus this one makes five
  assign tms_reset_hit = tck_rise && tms_s && (tms_cnt == `FTR_TMS_RESET_COUNT - 3'h1);

  always @* begin
    next_state = state;
    case (state)
      `FTR_ST_TLR: begin
        next_state = tms_s ? `FTR_ST_TLR : `FTR_ST_RTI;
      end
      `FTR_ST_RTI: begin
        next_state = tms_s ? `FTR_ST_SEL_DR : `FTR_ST_RTI;
      end
      `FTR_ST_SEL_DR: begin
        next_state = tms_s ? `FTR_ST_SEL_IR : `FTR_ST_CAP_DR;
      end
      `FTR_ST_CAP_DR: begin
        next_state = tms_s ? `FTR_ST_EX1_DR : `FTR_ST_SH_DR;
      end
      `FTR_ST_SH_DR: begin
        next_state = tms_s ? `FTR_ST_EX1_DR : `FTR_ST_SH_DR;
      end
      `FTR_ST_EX1_DR: begin
        next_state = tms_s ? `FTR_ST_UPD_DR : `FTR_ST_PAU_DR;
      end
      `FTR_ST_PAU_DR: begin
        next_state = tms_s ? `FTR_ST_EX2_DR : `FTR_ST_PAU_DR;
      end
      `FTR_ST_EX2_DR: begin
        next_state = tms_s ? `FTR_ST_UPD_DR : `FTR_ST_SH_DR;
      end
      `FTR_ST_UPD_DR: begin
        next_state = tms_s ? `FTR_ST_SEL_DR : `FTR_ST_RTI;
      end
      `FTR_ST_SEL_IR: begin
        next_state = tms_s ? `FTR_ST_TLR : `FTR_ST_CAP_IR;
      end
      `FTR_ST_CAP_IR: begin
        next_state = tms_s ? `FTR_ST_EX1_IR : `FTR_ST_SH_IR;
      end
      `FTR_ST_SH_IR: begin
        next_state = tms_s ? `FTR_ST_EX1_IR : `FTR_ST_SH_IR;
      end
      `FTR_ST_EX1_IR: begin
        next_state = tms_s ? `FTR_ST_UPD_IR : `FTR_ST_PAU_IR;
      end
      `FTR_ST_PAU_IR: begin
        next_state = tms_s ? `FTR_ST_EX2_IR : `FTR_ST_PAU_IR;
      end
      `FTR_ST_EX2_IR: begin
        next_state = tms_s ? `FTR_ST_UPD_IR : `FTR_ST_SH_IR;
      end
      `FTR_ST_UPD_IR: begin
        next_state = tms_s ? `FTR_ST_SEL_DR : `FTR_ST_RTI;
      end
      default: begin
        next_state = `FTR_ST_TLR;
      end
    endcase
  end

  // Test reset acts as a level on every system clock, with no test clock edge needed
  always @(posedge sys_clk_i) begin
    if (!rstn_i || !trst_n_s) begin
      state <= `FTR_ST_TLR;
    end else if (tms_reset_hit) begin
      state <= `FTR_ST_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!rstn_i || !trst_n_s) begin
      tms_cnt <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s || tms_reset_hit) begin
        tms_cnt <= 3'h0;
      end else begin
        tms_cnt <= tms_cnt + 3'h1;
      end
    end
  end

  // Power-up leaves the TAP unqualified; only a test reset or the five-high
  // sequence qualifies it, so system reset alone keeps the FIFO outputs off
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      tap_reset_done_o <= 1'b0;
    end else if (!trst_n_s || tms_reset_hit) begin
      tap_reset_done_o <= 1'b1;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      fifo_q_o      <= {DATA_WIDTH{1'b0}};
      fifo_q_oe_n_o <= 1'b1;
    end else begin
      fifo_q_o      <= fifo_q_i;
      fifo_q_oe_n_o <= ~tap_reset_done_o;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!rstn_i || !trst_n_s) begin
      ir    <= `FTR_IR_IDCODE;
      ir_sh <= {IRW{1'b0}};
    end else if (tck_rise) begin
      case (state)
        `FTR_ST_TLR: begin
          ir <= `FTR_IR_IDCODE;
        end
        `FTR_ST_CAP_IR: begin
          ir_sh <= `FTR_IR_CAPTURE;
        end
        `FTR_ST_SH_IR: begin
          ir_sh <= {tdi_s, ir_sh[IRW-1:1]};
        end
        `FTR_ST_UPD_IR: begin
          ir <= ir_sh;
        end
        default: begin
          ir <= ir;
        end
      endcase
    end
  end

  // Unsupported instructions fall back to the bypass bit
  always @(posedge sys_clk_i) begin
    if (!rstn_i || !trst_n_s) begin
      id_sh      <= {IDW{1'b0}};
      bypass_bit <= 1'b0;
    end else if (tck_rise) begin
      if (state == `FTR_ST_CAP_DR) begin
        id_sh      <= ID_CODE;
        bypass_bit <= 1'b0;
      end else if (state == `FTR_ST_SH_DR) begin
        if (sel_id) begin
          id_sh <= {tdi_s, id_sh[IDW-1:1]};
        end else begin
          bypass_bit <= tdi_s;
        end
      end
    end
  end

  // State is stable at the falling edge, so output and enable both follow it there
  always @(posedge sys_clk_i) begin
    if (!rstn_i || !trst_n_s) begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n_o <= ~shifting;
      if (state == `FTR_ST_SH_IR) begin
        tdo_o <= ir_sh[0];
      end else if (sel_id) begin
        tdo_o <= id_sh[0];
      end else begin
        tdo_o <= bypass_bit;
      end
    end
  end

endmodule
